// *** rtl/tpsg_regs.vh ***
// register offsets, field positions and constants of the timed pwm generator
`ifndef TPSG_REGS_VH
`define TPSG_REGS_VH
`define TPSG_OFF_CONTROL    8'h00
`define TPSG_OFF_STATUS     8'h04
`define TPSG_OFF_POLARITY   8'h08
`define TPSG_OFF_VERSION    8'h0c
`define TPSG_OFF_CABLE      8'h20
`define TPSG_OFF_IRQ_FLAG   8'h30
`define TPSG_OFF_IRQ_MASK   8'h34
`define TPSG_OFF_START_NS   8'h40
`define TPSG_OFF_START_S    8'h44
`define TPSG_OFF_WIDTH_NS   8'h48
`define TPSG_OFF_WIDTH_S    8'h4c
`define TPSG_OFF_PERIOD_NS  8'h50
`define TPSG_OFF_PERIOD_S   8'h54
`define TPSG_OFF_REPEAT     8'h58
`define TPSG_BIT_ENABLE     0
`define TPSG_BIT_VALID      1
`define TPSG_BIT_ERROR      0
`define TPSG_BIT_JUMP       1
`define TPSG_BIT_POL        0
`define TPSG_BIT_IRQ        0
`define TPSG_CABLE_W        16
`define TPSG_NS_PER_S       32'h3b9aca00
`define TPSG_HALF_STEP_NS   32'h0000000a
`define TPSG_RESP_OKAY      2'h0
`define TPSG_RESP_DECERR    2'h3
`define TPSG_POL_RESET      1'h1
`endif

// *** rtl/tpsg_time_add.v ***
// adds or subtracts two seconds plus nanoseconds times
`timescale 1ns/1ps
`default_nettype none
`include "tpsg_regs.vh"
module tpsg_time_add (
  input  wire [31:0] a_s_i,
  input  wire [31:0] a_ns_i,
  input  wire [31:0] b_s_i,
  input  wire [31:0] b_ns_i,
  input  wire        sub_i,
  output reg  [31:0] y_s_o,
  output reg  [31:0] y_ns_o
);
  reg [32:0] ns_sum;
  always @* begin
    ns_sum = 33'h000000000;
    if (sub_i) begin
      // borrow a second when nanoseconds underflow
      if (a_ns_i >= b_ns_i) begin
        y_ns_o = a_ns_i - b_ns_i;
        y_s_o  = a_s_i - b_s_i;
      end else begin
        y_ns_o = a_ns_i + `TPSG_NS_PER_S - b_ns_i;
        y_s_o  = a_s_i - b_s_i - 32'h00000001;
      end
    end else begin
      ns_sum = {1'b0, a_ns_i} + {1'b0, b_ns_i};
      if (ns_sum >= {1'b0, `TPSG_NS_PER_S}) begin
        y_ns_o = ns_sum[31:0] - `TPSG_NS_PER_S;
        y_s_o  = a_s_i + b_s_i + 32'h00000001;
      end else begin
        y_ns_o = ns_sum[31:0];
        y_s_o  = a_s_i + b_s_i;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/tpsg_time_ge.v ***
// compares two seconds plus nanoseconds times: a at or past b
`timescale 1ns/1ps
`default_nettype none
module tpsg_time_ge (
  input  wire [31:0] a_s_i,
  input  wire [31:0] a_ns_i,
  input  wire [31:0] b_s_i,
  input  wire [31:0] b_ns_i,
  output wire        ge_o
);
  assign ge_o = (a_s_i > b_s_i) || ((a_s_i == b_s_i) && (a_ns_i >= b_ns_i));
endmodule
`default_nettype wire

// *** rtl/tpsg_top.v ***
// timed pwm generator: axi4-lite register set and edge scheduler
// Contract
// - edges produced early by output delay
// - edge placed mid clock period
// - optional dual-edge operation halves error; not taken here, generator runs on the rising edge only
// - all registers 32-bit over axi4-lite
// - unmapped offsets answer decode error
// - control register at offset 0x00
// - status at 0x04, write clears flags
// - polarity at 0x08, version at 0x0c
// - cable delay register at 0x20
// - irq flag 0x30 clears, mask 0x34
// - start time ns 0x40, s 0x44
// - pulse width ns 0x48, s 0x4c
// - period ns 0x50, s 0x54
// - repeat count register at 0x58
// - assert = start - delay, deassert = +width
// - on reaching edge time drive, add period
// - stop at repeat count, zero endless
// - jump or disable stops, output idle
`timescale 1ns/1ps
`default_nettype none
`include "tpsg_regs.vh"
module tpsg_top #(
  parameter [31:0] VERSION    = 32'h01000000, // arbitrary value
  parameter [31:0] OUT_DLY_NS = 32'h00000000  // fixed pin delay of the output path
) (
  input  wire        mclk_i,
  input  wire        srst_i,
  input  wire        ce_i,
  input  wire [31:0] time_s_i,
  input  wire [31:0] time_ns_i,
  input  wire        time_jump_i,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [31:0] s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         signal_o,
  output reg         irq_o
);
  // control and configuration
  reg        enable_r;
  reg        valid_r;
  reg        pol_r;
  reg [`TPSG_CABLE_W-1:0] cable_r;
  reg        irq_mask_r;
  reg [31:0] start_ns_r;
  reg [31:0] start_s_r;
  reg [31:0] width_ns_r;
  reg [31:0] width_s_r;
  reg [31:0] period_ns_r;
  reg [31:0] period_s_r;
  reg [31:0] repeat_r;
  // status
  reg        err_r;
  reg        jump_r;
  reg        irq_flag_r;
  // generator state
  reg        run_r;
  reg        active_r;
  reg [31:0] on_s_r;
  reg [31:0] on_ns_r;
  reg [31:0] off_s_r;
  reg [31:0] off_ns_r;
  reg [31:0] count_r;
  reg        start_late_arm_q;
  // time arrives from the time source on this clock, so no synchroniser
  // half a time step more lead rounds each edge to the nearest step
  wire [31:0] dly_ns = OUT_DLY_NS + {{(32-`TPSG_CABLE_W){1'b0}}, cable_r}
                       + `TPSG_HALF_STEP_NS;
  wire [31:0] first_on_s;
  wire [31:0] first_on_ns;
  wire [31:0] first_off_s;
  wire [31:0] first_off_ns;
  wire [31:0] next_on_s;
  wire [31:0] next_on_ns;
  wire [31:0] next_off_s;
  wire [31:0] next_off_ns;
  wire        on_due;
  wire        off_due;
  wire        start_late;

  tpsg_time_add u_first_on (
    .a_s_i (start_s_r), .a_ns_i (start_ns_r), .b_s_i (32'h00000000), .b_ns_i (dly_ns),
    .sub_i (1'b1), .y_s_o (first_on_s), .y_ns_o (first_on_ns));
  tpsg_time_add u_first_off (
    .a_s_i (first_on_s), .a_ns_i (first_on_ns), .b_s_i (width_s_r), .b_ns_i (width_ns_r),
    .sub_i (1'b0), .y_s_o (first_off_s), .y_ns_o (first_off_ns));
  tpsg_time_add u_next_on (
    .a_s_i (on_s_r), .a_ns_i (on_ns_r), .b_s_i (period_s_r), .b_ns_i (period_ns_r),
    .sub_i (1'b0), .y_s_o (next_on_s), .y_ns_o (next_on_ns));
  tpsg_time_add u_next_off (
    .a_s_i (off_s_r), .a_ns_i (off_ns_r), .b_s_i (period_s_r), .b_ns_i (period_ns_r),
    .sub_i (1'b0), .y_s_o (next_off_s), .y_ns_o (next_off_ns));
  tpsg_time_ge u_on_due (
    .a_s_i (time_s_i), .a_ns_i (time_ns_i), .b_s_i (on_s_r), .b_ns_i (on_ns_r),
    .ge_o (on_due));
  tpsg_time_ge u_off_due (
    .a_s_i (time_s_i), .a_ns_i (time_ns_i), .b_s_i (off_s_r), .b_ns_i (off_ns_r),
    .ge_o (off_due));
  tpsg_time_ge u_late (
    .a_s_i (time_s_i), .a_ns_i (time_ns_i), .b_s_i (first_on_s), .b_ns_i (first_on_ns),
    .ge_o (start_late));

  // bus handshake: address and data taken together, one write and one read at a time
  wire       wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire       rd_go  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire [7:0] wa     = s_axi_awaddr[7:0];
  wire [7:0] ra     = s_axi_araddr[7:0];
  wire       wr_hit = wr_go && (s_axi_awaddr[31:8] == 24'h000000);
  // clear-on-write flags: a write of one clears, a write of zero leaves
  wire       clr_st = wr_hit && (wa == `TPSG_OFF_STATUS);
  wire       clr_irq = wr_hit && (wa == `TPSG_OFF_IRQ_FLAG);
  wire       dis_req = wr_hit && (wa == `TPSG_OFF_CONTROL)
                       && !s_axi_wdata[`TPSG_BIT_ENABLE];
  wire       arm_req = wr_hit && (wa == `TPSG_OFF_CONTROL)
                       && s_axi_wdata[`TPSG_BIT_ENABLE] && s_axi_wdata[`TPSG_BIT_VALID];

  reg        wr_ok;
  reg        rd_ok;
  reg [31:0] rd_val;
  always @* begin
    wr_ok = 1'b1;
    case (wa)
      `TPSG_OFF_CONTROL, `TPSG_OFF_STATUS, `TPSG_OFF_POLARITY, `TPSG_OFF_VERSION,
      `TPSG_OFF_CABLE, `TPSG_OFF_IRQ_FLAG, `TPSG_OFF_IRQ_MASK, `TPSG_OFF_START_NS,
      `TPSG_OFF_START_S, `TPSG_OFF_WIDTH_NS, `TPSG_OFF_WIDTH_S, `TPSG_OFF_PERIOD_NS,
      `TPSG_OFF_PERIOD_S, `TPSG_OFF_REPEAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    if (s_axi_awaddr[31:8] != 24'h000000) begin
      wr_ok = 1'b0;
    end
    rd_ok  = (s_axi_araddr[31:8] == 24'h000000);
    rd_val = 32'h00000000;
    case (ra)
      `TPSG_OFF_CONTROL: begin
        rd_val[`TPSG_BIT_ENABLE] = enable_r;
        rd_val[`TPSG_BIT_VALID]  = valid_r;
      end
      `TPSG_OFF_STATUS: begin
        rd_val[`TPSG_BIT_ERROR] = err_r;
        rd_val[`TPSG_BIT_JUMP]  = jump_r;
      end
      `TPSG_OFF_POLARITY:  rd_val[`TPSG_BIT_POL] = pol_r;
      `TPSG_OFF_VERSION:   rd_val = VERSION;
      `TPSG_OFF_CABLE:     rd_val[`TPSG_CABLE_W-1:0] = cable_r;
      `TPSG_OFF_IRQ_FLAG:  rd_val[`TPSG_BIT_IRQ] = irq_flag_r;
      `TPSG_OFF_IRQ_MASK:  rd_val[`TPSG_BIT_IRQ] = irq_mask_r;
      `TPSG_OFF_START_NS:  rd_val = start_ns_r;
      `TPSG_OFF_START_S:   rd_val = start_s_r;
      `TPSG_OFF_WIDTH_NS:  rd_val = width_ns_r;
      `TPSG_OFF_WIDTH_S:   rd_val = width_s_r;
      `TPSG_OFF_PERIOD_NS: rd_val = period_ns_r;
      `TPSG_OFF_PERIOD_S:  rd_val = period_s_r;
      `TPSG_OFF_REPEAT:    rd_val = repeat_r;
      default:             rd_ok = 1'b0;
    endcase
  end

  // bus slave
  always @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TPSG_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TPSG_RESP_OKAY;
    end else if (ce_i) begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      s_axi_arready <= rd_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TPSG_RESP_OKAY : `TPSG_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_val : 32'h00000000;
        s_axi_rresp  <= rd_ok ? `TPSG_RESP_OKAY : `TPSG_RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration writes; byte strobes are ignored, full words assumed
  always @(posedge mclk_i) begin
    if (srst_i) begin
      enable_r    <= 1'b0;
      valid_r     <= 1'b0;
      pol_r       <= `TPSG_POL_RESET;
      cable_r     <= {`TPSG_CABLE_W{1'b0}};
      irq_mask_r  <= 1'b0;
      start_ns_r  <= 32'h00000000;
      start_s_r   <= 32'h00000000;
      width_ns_r  <= 32'h00000000;
      width_s_r   <= 32'h00000000;
      period_ns_r <= 32'h00000000;
      period_s_r  <= 32'h00000000;
      repeat_r    <= 32'h00000000;
    end else if (ce_i) begin
      if (wr_hit) begin
        case (wa)
          `TPSG_OFF_CONTROL: begin
            enable_r <= s_axi_wdata[`TPSG_BIT_ENABLE];
            valid_r  <= s_axi_wdata[`TPSG_BIT_VALID];
          end
          `TPSG_OFF_POLARITY:  pol_r <= s_axi_wdata[`TPSG_BIT_POL];
          `TPSG_OFF_CABLE:     cable_r <= s_axi_wdata[`TPSG_CABLE_W-1:0];
          `TPSG_OFF_IRQ_MASK:  irq_mask_r <= s_axi_wdata[`TPSG_BIT_IRQ];
          `TPSG_OFF_START_NS:  start_ns_r <= s_axi_wdata;
          `TPSG_OFF_START_S:   start_s_r <= s_axi_wdata;
          `TPSG_OFF_WIDTH_NS:  width_ns_r <= s_axi_wdata;
          `TPSG_OFF_WIDTH_S:   width_s_r <= s_axi_wdata;
          `TPSG_OFF_PERIOD_NS: period_ns_r <= s_axi_wdata;
          `TPSG_OFF_PERIOD_S:  period_s_r <= s_axi_wdata;
          `TPSG_OFF_REPEAT:    repeat_r <= s_axi_wdata;
          default: ;
        endcase
      end else if ((run_r && time_jump_i) || (start_late_arm_q && start_late)) begin
        enable_r <= 1'b0;
        valid_r  <= 1'b0;
      end
    end
  end

  // a start that is already in the past is refused as an error
  always @(posedge mclk_i) begin
    if (srst_i) begin
      start_late_arm_q <= 1'b0;
    end else if (ce_i) begin
      start_late_arm_q <= arm_req;
    end
  end

  // generator; rising edge only, so error stays at half a time step
  // dual-edge option not taken: it would need a second output register
  wire stop_now = time_jump_i || dis_req || (start_late_arm_q && start_late);
  wire err_evt  = run_r && (time_jump_i || dis_req) || (start_late_arm_q && start_late);
  always @(posedge mclk_i) begin
    if (srst_i) begin
      run_r      <= 1'b0;
      active_r   <= 1'b0;
      on_s_r     <= 32'h00000000;
      on_ns_r    <= 32'h00000000;
      off_s_r    <= 32'h00000000;
      off_ns_r   <= 32'h00000000;
      count_r    <= 32'h00000000;
      signal_o   <= ~`TPSG_POL_RESET;
      err_r      <= 1'b0;
      jump_r     <= 1'b0;
      irq_flag_r <= 1'b0;
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      // set wins over a clear in the same cycle
      err_r      <= err_evt | (err_r & ~(clr_st & s_axi_wdata[`TPSG_BIT_ERROR]));
      jump_r     <= time_jump_i | (jump_r & ~(clr_st & s_axi_wdata[`TPSG_BIT_JUMP]));
      irq_flag_r <= err_evt | (irq_flag_r & ~(clr_irq & s_axi_wdata[`TPSG_BIT_IRQ]));
      irq_o      <= irq_mask_r & (err_evt | (irq_flag_r & ~(clr_irq & s_axi_wdata[`TPSG_BIT_IRQ])));
      if (stop_now) begin
        run_r    <= 1'b0;
        active_r <= 1'b0;
        signal_o <= ~pol_r;
      end else if (start_late_arm_q) begin
        run_r    <= 1'b1;
        active_r <= 1'b0;
        count_r  <= 32'h00000000;
        on_s_r   <= first_on_s;
        on_ns_r  <= first_on_ns;
        off_s_r  <= first_off_s;
        off_ns_r <= first_off_ns;
        signal_o <= ~pol_r;
      end else if (run_r) begin
        if (!active_r && on_due) begin
          active_r <= 1'b1;
          signal_o <= pol_r;
          on_s_r   <= next_on_s;
          on_ns_r  <= next_on_ns;
        end else if (active_r && off_due) begin
          active_r <= 1'b0;
          signal_o <= ~pol_r;
          off_s_r  <= next_off_s;
          off_ns_r <= next_off_ns;
          count_r  <= count_r + 32'h00000001;
          if ((repeat_r != 32'h00000000) && (count_r + 32'h00000001 == repeat_r)) begin
            run_r <= 1'b0;
          end
        end
      end else begin
        signal_o <= ~pol_r;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the timed pwm generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] VER = 32'h0000_0c5a; // arbitrary value
  localparam logic [31:0] NS1 = 32'h3b9aca00;
  localparam logic [7:0]  RW_OFF [7] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h58};
  localparam logic [7:0]  HOLES [4] = '{8'h10, 8'h24, 8'h5c, 8'hfc};
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        time_jump_i = 1'b0;
  logic        jmp = 1'b0;
  logic        ce = 1'b1;
  logic [31:0] time_s_i = 32'd5;
  logic [31:0] time_ns_i = NS1 - 32'd20000;
  logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic        signal_o, irq_o;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  tpsg_top #(.VERSION(VER)) DUT (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce),
    .time_s_i(time_s_i), .time_ns_i(time_ns_i), .time_jump_i(time_jump_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .signal_o(signal_o), .irq_o(irq_o));
  tpsg_axi_host u_host (.mclk_i(mclk_i), .awready_i(awready), .arready_i(arready),
    .bresp_i(bresp), .rresp_i(rresp), .rdata_i(rdata), .awvalid_o(awvalid), .wvalid_o(wvalid),
    .arvalid_o(arvalid), .awaddr_o(awaddr), .wdata_o(wdata), .araddr_o(araddr));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // reference time: 20 ns a cycle, carry at one second, jumps by 100 s
  always @(negedge mclk_i) begin
    cyc = cyc + 1;
    time_jump_i <= jmp;
    if (jmp) time_s_i <= time_s_i + 32'd100;
    else if (time_ns_i >= NS1 - 32'd20) begin
      time_s_i  <= time_s_i + 32'd1;
      time_ns_i <= time_ns_i + 32'd20 - NS1;
    end else time_ns_i <= time_ns_i + 32'd20;
    if (cyc > 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr(a, d, r);
    chk({30'h0, r}, 32'h0, "write response");
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] e);
    logic [1:0]  r;
    logic [31:0] d;
    u_host.rd(a, d, r);
    chk({30'h0, r}, 32'h0, "read response");
    chk(d, e, "read data");
  endtask
  // checks the reference time seen at the edge that brought the level
  task automatic edge_at(input logic lvl, input logic [31:0] es, input logic [31:0] ens);
    do @(negedge mclk_i); while (signal_o !== lvl);
    chk(time_s_i, es, "edge second");
    chk(time_ns_i, ens, "edge nanosecond");
  endtask
  task automatic quiet(input int n, input logic lvl);
    repeat (n) begin
      @(negedge mclk_i);
      chk({31'h0, signal_o}, {31'h0, lvl}, "output level");
    end
  endtask
  task automatic arm(input logic [31:0] s, input logic [31:0] ns, input logic [31:0] w,
                     input logic [31:0] p, input logic [31:0] cnt);
    wrk(8'h40, ns);
    wrk(8'h44, s);
    wrk(8'h48, w);
    wrk(8'h4c, 32'h0);
    wrk(8'h50, p);
    wrk(8'h54, 32'h0);
    wrk(8'h58, cnt);
    wrk(8'h00, 32'h3);
  endtask
  task automatic t_regs;
    rdk(8'h04, 32'h0);
    rdk(8'h08, 32'h1);
    wrk(8'h0c, 32'h0);
    rdk(8'h0c, VER);
    wrk(8'h00, 32'hffff_fffe);
    rdk(8'h00, 32'h2);
    wrk(8'h00, 32'h0);
    wrk(8'h20, 32'hffff_ffff);
    rdk(8'h20, 32'h0000_ffff);
    wrk(8'h34, 32'hffff_ffff);
    rdk(8'h34, 32'h1);
    wrk(8'h34, 32'h0);
    foreach (RW_OFF[i]) begin
      wrk(RW_OFF[i], 32'ha500_0000 | 32'(i));
      rdk(RW_OFF[i], 32'ha500_0000 | 32'(i));
    end
  endtask
  task automatic t_unmapped;
    logic [1:0]  r;
    logic [31:0] d;
    foreach (HOLES[i]) begin
      u_host.wr(HOLES[i], 32'hffff_ffff, r);
      chk({30'h0, r}, 32'h3, "write decode error");
      u_host.rd(HOLES[i], d, r);
      chk({30'h0, r}, 32'h3, "read decode error");
      chk(d, 32'h0, "refused read data");
    end
  endtask
  // start across a second boundary so the cable delay borrows a second
  task automatic t_pulse;
    wrk(8'h20, 32'd40);
    arm(32'd6, 32'd0, 32'd100, 32'd200, 32'd2);
    edge_at(1'b1, 32'd5, NS1 - 32'd40);
    edge_at(1'b0, 32'd6, 32'd60);
    edge_at(1'b1, 32'd6, 32'd160);
    edge_at(1'b0, 32'd6, 32'd260);
    quiet(40, 1'b0);
    rdk(8'h04, 32'h0);
  endtask
  // pin targets 3965 and 4025 lie nearer to 3960 and 4020 than to the next step
  task automatic t_endless;
    wrk(8'h20, 32'd35);
    arm(32'd6, 32'd4000, 32'd60, 32'd100, 32'd0);
    for (int i = 0; i < 5; i++) begin
      edge_at(1'b1, 32'd6, 32'(3960 + 100 * i));
      edge_at(1'b0, 32'd6, 32'(4020 + 100 * i));
    end
    wrk(8'h00, 32'h0);
    quiet(10, 1'b0);
    rdk(8'h04, 32'h1);
    rdk(8'h30, 32'h1);
    chk({31'h0, irq_o}, 32'h0, "masked interrupt");
    wrk(8'h04, 32'h1);
    wrk(8'h30, 32'h1);
    rdk(8'h04, 32'h0);
    rdk(8'h30, 32'h0);
  endtask
  task automatic t_jump;
    wrk(8'h34, 32'h1);
    arm(32'd6, 32'd8000, 32'd100, 32'd200, 32'd0);
    edge_at(1'b1, 32'd6, 32'd7960);
    @(posedge mclk_i);
    jmp = 1'b1;
    @(posedge mclk_i);
    jmp = 1'b0;
    quiet(5, 1'b0);
    rdk(8'h04, 32'h3);
    chk({31'h0, irq_o}, 32'h1, "raised interrupt");
    rdk(8'h00, 32'h0);
    wrk(8'h30, 32'h1);
    rdk(8'h30, 32'h0);
    chk({31'h0, irq_o}, 32'h0, "cleared interrupt");
    wrk(8'h04, 32'h3);
    arm(32'd1, 32'd0, 32'd100, 32'd200, 32'd0);
    rdk(8'h04, 32'h1);
    rdk(8'h00, 32'h0);
    quiet(5, 1'b0);
    wrk(8'h08, 32'h0);
    rdk(8'h08, 32'h0);
    quiet(5, 1'b1);
    // a jump while the clock enable is low must leave no trace
    @(negedge mclk_i);
    ce = 1'b0;
    @(posedge mclk_i);
    jmp = 1'b1;
    @(posedge mclk_i);
    jmp = 1'b0;
    @(negedge mclk_i);
    @(negedge mclk_i);
    ce = 1'b1;
    rdk(8'h04, 32'h1);
  endtask
  initial begin
    repeat (3) @(negedge mclk_i);
    srst_i = 1'b0;
    t_regs();
    t_unmapped();
    t_pulse();
    t_endless();
    t_jump();
    complete_run();
  end
endmodule
`default_nettype wire

// *** tb/tpsg_axi_host.sv ***
// axi4-lite master model for the register port
`timescale 1ns/1ps
`default_nettype none
module tpsg_axi_host (
  input  wire logic        mclk_i,
  input  wire logic        awready_i,
  input  wire logic        arready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic [31:0] rdata_i,
  output var  logic        awvalid_o,
  output var  logic        wvalid_o,
  output var  logic        arvalid_o,
  output var  logic [31:0] awaddr_o,
  output var  logic [31:0] wdata_o,
  output var  logic [31:0] araddr_o
);
  initial begin
    awvalid_o = 1'b0;
    wvalid_o  = 1'b0;
    arvalid_o = 1'b0;
    awaddr_o  = 32'h0;
    wdata_o   = 32'h0;
    araddr_o  = 32'h0;
  end
  // single aligned full words only, bready and rready stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(negedge mclk_i);
    awaddr_o  = {24'h0, a};
    wdata_o   = d;
    awvalid_o = 1'b1;
    wvalid_o  = 1'b1;
    do @(posedge mclk_i); while (awready_i !== 1'b1);
    r = bresp_i;
    @(negedge mclk_i);
    awvalid_o = 1'b0;
    wvalid_o  = 1'b0;
    // released lines flip so a stale value is never taken as valid
    awaddr_o  = ~awaddr_o;
    wdata_o   = ~wdata_o;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(negedge mclk_i);
    araddr_o  = {24'h0, a};
    arvalid_o = 1'b1;
    do @(posedge mclk_i); while (arready_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    @(negedge mclk_i);
    arvalid_o = 1'b0;
    araddr_o  = ~araddr_o;
  endtask
endmodule
`default_nettype wire

// *** tb/tpsg_checker.sv ***
// concurrent checks on the ports of the timed pwm generator
`timescale 1ns/1ps
`default_nettype none
module tpsg_checker #(
  parameter logic [31:0] VERSION = 32'h0
) (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic        ce_i,
  input wire logic        time_jump_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        signal_o,
  input wire logic        irq_o
);
  function automatic logic hit(input logic [31:0] a);
    return a[31:8] == 24'h0 && a[7:0] inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h30,
      8'h34, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h58};
  endfunction
  wire logic wr_take = ce_i && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire logic rd_take = ce_i && s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire logic aw_hit = hit(s_axi_awaddr);
  wire logic ar_hit = hit(s_axi_araddr);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_write_answer: assert property (wr_take |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not answered one cycle after it was taken");
  a_write_decode: assert property (wr_take |=> s_axi_bresp == ($past(aw_hit) ? 2'h0 : 2'h3))
    else $error("write response does not match the address map");
  a_read_decode: assert property (rd_take |=> s_axi_rvalid && s_axi_rresp == ($past(ar_hit) ? 2'h0 : 2'h3))
    else $error("read response does not match the address map");
  a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write ready held longer than one cycle");
  a_version_read: assert property (rd_take && s_axi_araddr == 32'h0c |=> s_axi_rdata == VERSION)
    else $error("version register read wrong value");
  a_jump_quiet: assert property (ce_i && time_jump_i |=> ##1 $stable(signal_o)[*3])
    else $error("output moved after a time jump");
  a_reset_quiet: assert property (disable iff (1'b0) srst_i && ce_i |=> !s_axi_bvalid && !s_axi_rvalid && !irq_o)
    else $error("outputs active after reset edge");
  c_refused: cover property (wr_take && !aw_hit);
  c_pulse: cover property ($rose(signal_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind tpsg_top tpsg_checker #(.VERSION(VERSION)) u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
  .ce_i(ce_i), .time_jump_i(time_jump_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .signal_o(signal_o), .irq_o(irq_o));
`default_nettype wire
